/* File: rtl/uacb_ctrl.sv */
`timescale 1ns/1ns
`default_nettype none
`include "uacb_defs.svh"

// Overview of operation
// - Transmitter enable clear aborts, flushes, floats transmit pin.
// - Transmit pin driven only with transmitter and port enables set.
// - Receiver enable clear aborts, flushes receiver, holds its input line idle high.
// - Receiver active only with receiver and port enables set.
// - Bit rate is clock over 64(N+1), or 16(N+1) in fast mode.
// - Free-running 8-bit timer set by divisor 0..255 sets rate.
// - Address bit is data bit 7, or ninth bit in 9-bit mode.
// - Address word with detection on is stored and may interrupt.
// - Non-address word with detection on is dropped, no interrupt.
// - Clock off plus wake enable: falling line edge requests wake.
// - No pin wake while clock runs or wake enable is zero.
// - Receive enable lets overrun or data-available set interrupt.
// - Idle enable lets transmitter idle set interrupt.
// - Empty enable lets transmit-empty set interrupt.
// - Single-line off: shared pin is receiver input only.
// - Single-line on: shared pin per enables; both on means receive.
// - Upper seven bits of single-line register read zero.
// - One data byte: written for transmit, read gives received byte.
// - Port disable clears both enables, keeps other controls.
module uacb_ctrl (
   // Clock and reset
   input  wire logic                 pclk,
   input  wire logic                 presetn,
   // APB slave
   input  wire logic [11:0]          paddr,
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [31:0]          pwdata,
   output logic [31:0]               prdata,
   output logic                      pready,
   output logic                      pslverr,
   // Frame logic side
   input  wire uacb_pkg::uacb_flags_t flags_i,
   input  wire logic                 rx_valid,
   input  wire uacb_pkg::uacb_rxw_t  rx_word,
   input  wire logic                 ser_tx_bit,
   input  wire logic                 clk_off,
   output logic                      port_run,
   output logic                      tx_run,
   output logic                      rx_run,
   output logic                      word_length_select,
   output logic                      baud_tick,
   output logic [7:0]                tx_data,
   output logic                      tx_load,
   output logic                      rx_taken,
   output logic                      rx_read,
   output logic                      rx_line,
   output logic                      irq_set,
   output logic                      wake_req,
   // Pins
   output uacb_pkg::uacb_pin_t       tx_pin,
   input  wire logic                 rxtx_pin_i,
   output uacb_pkg::uacb_pin_t       rxtx_pin
);
   import uacb_pkg::*;

   uacb_state_t s;
   uacb_state_t n;
   logic        wr_acc;
   logic        rd_acc;
   logic        setup;
   logic        abit;
   logic [5:0]  pre_top;

   ////////////////////////////////////////////////////////////////////
   // Address decode, shared by error answer and access strobes
   function automatic logic map_ok(input logic [11:0] a);
      map_ok = (a == `UACB_OFF_CTRL2) || (a == `UACB_OFF_SLINE) ||
               (a == `UACB_OFF_DATA)  || (a == `UACB_OFF_DIV)   ||
               (a == `UACB_OFF_PORT)  || (a == `UACB_OFF_STAT);
   endfunction

   // Bus phase decode
   assign setup  = psel && !penable;
   assign wr_acc = psel && penable && pwrite && map_ok(paddr);
   assign rd_acc = psel && penable && !pwrite && map_ok(paddr);

   // Zero wait states; data was prepared during setup
   assign pready  = 1'b1;
   assign pslverr = psel && penable && !map_ok(paddr);
   assign prdata  = s.prd;

   // Address bit of the incoming word
   // address bit select
   assign abit = s.word_length_select ? rx_word.received_ninth_bit
                                      : rx_word.data[7];

   // Prescaler length from the speed bit
   // speed mode factor
   assign pre_top = s.ctrl[`UACB_B_SPD] ? `UACB_PRE_HIGH
                                         : `UACB_PRE_LOW;

   ////////////////////////////////////////////////////////////////////
   // Next-state logic
   always_comb begin
      n          = s;
      n.tick     = 1'b0;
      n.tx_load  = 1'b0;
      n.rx_taken = 1'b0;
      n.rx_read  = 1'b0;
      n.irq_set  = 1'b0;
      n.wake_req = 1'b0;
      n.pin_q    = rxtx_pin_i;
      n.flg_q    = flags_i;

      // Register writes take effect at the access edge
      if (wr_acc) begin
         unique case (paddr)
            `UACB_OFF_CTRL2: n.ctrl = pwdata[7:0];
            `UACB_OFF_SLINE: n.single_line_mode = pwdata[0];
            `UACB_OFF_DATA: begin
               // A write while the holding byte is full is dropped
               // transmit byte
               if (flags_i.transmit_empty_flag) begin
                  n.txd     = pwdata[7:0];
                  n.tx_load = 1'b1;
               end
            end
            `UACB_OFF_DIV: n.divisor_bits = pwdata[7:0];
            `UACB_OFF_PORT: begin
               n.port_global_on     = pwdata[`UACB_B_PORTON];
               n.word_length_select = pwdata[`UACB_B_WORD9];
            end
            `UACB_OFF_STAT: n.prd = s.prd;
         endcase
      end

      // Data read tells the flag logic the byte was consumed
      if (rd_acc && (paddr == `UACB_OFF_DATA)) begin
         n.rx_read = 1'b1;
      end

      // Enables cannot stand while the port is off
      // clear both enables
      if (!n.port_global_on) begin
         n.ctrl[`UACB_B_TXON] = 1'b0;
         n.ctrl[`UACB_B_RXON] = 1'b0;
      end

      // Received word, filtered by address detection
      if (rx_valid && rx_run) begin
         if (!(s.ctrl[`UACB_B_ADDR] && !abit)) begin
            n.rxd      = rx_word.data;
            n.rx9      = rx_word.received_ninth_bit;
            n.rx_taken = 1'b1;
         end
      end

      // Read data is latched in setup so it stands through access
      if (setup) begin
         unique case (paddr)
            `UACB_OFF_CTRL2: n.prd = 32'(s.ctrl);
            `UACB_OFF_SLINE: n.prd = 32'(s.single_line_mode);
            `UACB_OFF_DATA:  n.prd = 32'(s.rxd);
            `UACB_OFF_DIV:   n.prd = 32'(s.divisor_bits);
            `UACB_OFF_PORT:  n.prd = 32'({s.word_length_select,
                                          s.port_global_on});
            `UACB_OFF_STAT:  n.prd = 32'({s.rx9, flags_i});
            default:         n.prd = `UACB_WORD_ZERO;
         endcase
      end

      // Baud timer: prescaler then divisor countdown
      // restart while port is off
      if (!s.port_global_on) begin
         n.pre = pre_top;
         n.cnt = s.divisor_bits;
      end else if (s.pre == `UACB_PRE_ZERO) begin
         n.pre = pre_top;
         if (s.cnt == `UACB_CNT_ZERO) begin
            n.cnt  = s.divisor_bits;
            n.tick = 1'b1;
         end else begin
            n.cnt = s.cnt - 8'h01;
         end
      end else begin
         n.pre = s.pre - 6'h01;
      end

      // Falling line edge while the serial clock is stopped
      // wake request
      n.wake_req = clk_off && s.ctrl[`UACB_B_WAKE] &&
                   s.pin_q && !rxtx_pin_i;

      // Interrupt request on enabled flag rising edges
      // receive sources
      if (s.ctrl[`UACB_B_RIE] &&
          ((flags_i.overrun_flag && !s.flg_q.overrun_flag) ||
           (flags_i.receive_available_flag &&
            !s.flg_q.receive_available_flag) ||
           n.wake_req)) begin
         n.irq_set = 1'b1;
      end
      if (s.ctrl[`UACB_B_TX_IDLE_IRQ_ON] && flags_i.transmitter_idle_flag &&
          !s.flg_q.transmitter_idle_flag) begin
         n.irq_set = 1'b1;
      end
      if (s.ctrl[`UACB_B_TX_EMPTY_IRQ_ON] && flags_i.transmit_empty_flag &&
          !s.flg_q.transmit_empty_flag) begin
         n.irq_set = 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // State register; data and divisor bytes clear to zero
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s      <= '0;
         s.ctrl <= `UACB_CTRL2_RST;
         s.txd  <= `UACB_BYTE_RST;
         s.pre  <= `UACB_PRE_LOW;
      end else begin
         s <= n;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Outputs to the frame logic
   assign port_run           = s.port_global_on;
   assign tx_run             = s.port_global_on && s.ctrl[`UACB_B_TXON];
   assign rx_run             = s.port_global_on && s.ctrl[`UACB_B_RXON];
   assign word_length_select = s.word_length_select;
   assign baud_tick          = s.tick;
   assign tx_data            = s.txd;
   assign tx_load            = s.tx_load;
   assign rx_taken           = s.rx_taken;
   assign rx_read            = s.rx_read;
   assign irq_set            = s.irq_set;
   assign wake_req           = s.wake_req;

   // Receiver sees idle-high when shut off, so no false start bit
   // receiver detached
   assign rx_line = rx_run ? rxtx_pin_i : 1'b1;

   // Pin drivers; in single-line mode the shared pin carries data
   // float when off
   assign tx_pin.o    = ser_tx_bit;
   assign tx_pin.oe_n = !(tx_run && !s.single_line_mode);
   assign rxtx_pin.o    = ser_tx_bit;
   assign rxtx_pin.oe_n = !(s.single_line_mode && tx_run && !rx_run);

   ////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // Helper: cycles since the last tick, armed on a clean interval.
   // Two ticks must pass after a setting change, because the count
   // already running may have been loaded with the old setting.
   logic [16:0] gap_q;
   logic [1:0]  arm_q;
   logic [16:0] per;
   assign per = (s.ctrl[`UACB_B_SPD] ? `UACB_FAC_HIGH : `UACB_FAC_LOW)
                * (17'(s.divisor_bits) + 17'h00001);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gap_q   <= 17'h00000;
         arm_q   <= 2'h0;
      end else begin
         gap_q   <= s.tick ? 17'h00000 : gap_q + 17'h00001;
         if (!s.port_global_on || (n.divisor_bits != s.divisor_bits) ||
             (n.ctrl[`UACB_B_SPD] != s.ctrl[`UACB_B_SPD])) begin
            arm_q <= 2'h0;
         end else if (s.tick && (arm_q != 2'h2)) begin
            arm_q <= arm_q + 2'h1;
         end
      end
   end

   property p_tick_period;
      baud_tick && (arm_q == 2'h2) |-> (gap_q + 17'h00001) == per;
   endproperty
   a_tick_period: assert property (p_tick_period)
      else $error("baud tick spacing wrong");

   // Reload takes the divisor of the cycle before; a write may land then
   property p_timer_restart;
      !port_run |=> !baud_tick && (s.cnt == $past(s.divisor_bits));
   endproperty
   a_timer_restart: assert property (p_timer_restart)
      else $error("timer runs while port off");

   property p_tx_drive;
      !tx_pin.oe_n |-> port_run && s.ctrl[`UACB_B_TXON];
   endproperty
   a_tx_drive: assert property (p_tx_drive)
      else $error("tx pin driven while disabled");

   property p_tx_float;
      $fell(s.ctrl[`UACB_B_TXON]) |-> tx_pin.oe_n && rxtx_pin.oe_n;
   endproperty
   a_tx_float: assert property (p_tx_float)
      else $error("pin not floated after tx disable");

   property p_shared_rx;
      (!s.single_line_mode || rx_run) |-> rxtx_pin.oe_n;
   endproperty
   a_shared_rx: assert property (p_shared_rx)
      else $error("shared pin driven in receive use");

   property p_addr_drop;
      rx_valid && rx_run && s.ctrl[`UACB_B_ADDR] && !abit
         |=> !rx_taken && (s.rxd == $past(s.rxd));
   endproperty
   a_addr_drop: assert property (p_addr_drop)
      else $error("data word not dropped");

   property p_addr_keep;
      rx_valid && rx_run && abit |=>
         rx_taken && (s.rxd == $past(rx_word.data));
   endproperty
   a_addr_keep: assert property (p_addr_keep)
      else $error("address word not stored");

   property p_rie;
      s.ctrl[`UACB_B_RIE] && $rose(flags_i.receive_available_flag)
         |=> irq_set;
   endproperty
   a_rie: assert property (p_rie)
      else $error("receive interrupt missing");

   property p_wake_only_off;
      wake_req |-> $past(clk_off) && $past(s.ctrl[`UACB_B_WAKE]);
   endproperty
   a_wake_only_off: assert property (p_wake_only_off)
      else $error("wake while clock runs");

   property p_wake_edge;
      clk_off && s.ctrl[`UACB_B_WAKE] && $fell(rxtx_pin_i)
         |=> wake_req;
   endproperty
   a_wake_edge: assert property (p_wake_edge)
      else $error("wake request missing");

   property p_sline_read;
      rd_acc && (paddr == `UACB_OFF_SLINE) |-> prdata[31:1] == 31'h0;
   endproperty
   a_sline_read: assert property (p_sline_read)
      else $error("single-line upper bits not zero");

   property p_port_off;
      !port_run |-> !tx_run && !rx_run ##1 !s.ctrl[`UACB_B_TXON];
   endproperty
   a_port_off: assert property (p_port_off)
      else $error("enable kept while port off");

   // A load pulse only follows an accepted write into an empty holding byte
   property p_tx_load;
      tx_load |-> $past(wr_acc) && $past(flags_i.transmit_empty_flag);
   endproperty
   a_tx_load: assert property (p_tx_load)
      else $error("transmit byte loaded while full");

   property p_rx_idle;
      !rx_run |-> rx_line;
   endproperty
   a_rx_idle: assert property (p_rx_idle)
      else $error("receiver sees line while disabled");

endmodule
`default_nettype wire

/* File: rtl/uacb_defs.svh */
`ifndef UACB_DEFS_SVH
`define UACB_DEFS_SVH

// Register byte offsets on the APB window
`define UACB_OFF_CTRL2 12'h000
`define UACB_OFF_SLINE 12'h004
`define UACB_OFF_DATA  12'h008
`define UACB_OFF_DIV   12'h00c
`define UACB_OFF_PORT  12'h010
`define UACB_OFF_STAT  12'h014

// Field positions in serial_control_two
`define UACB_B_TXON 7
`define UACB_B_RXON 6
`define UACB_B_SPD  5
`define UACB_B_ADDR 4
`define UACB_B_WAKE 3
`define UACB_B_RIE  2
`define UACB_B_TX_IDLE_IRQ_ON 1
`define UACB_B_TX_EMPTY_IRQ_ON 0

// Field positions in the port control register
`define UACB_B_PORTON 0
`define UACB_B_WORD9  1

// Reset values
`define UACB_CTRL2_RST 8'h00
`define UACB_BYTE_RST  8'h00
`define UACB_WORD_ZERO 32'h0000_0000

// Prescaler last count: 64 or 16 clocks per divisor step
`define UACB_PRE_LOW  6'h3f
`define UACB_PRE_HIGH 6'h0f
`define UACB_PRE_ZERO 6'h00
`define UACB_CNT_ZERO 8'h00

// Same factors, wide, for period arithmetic
`define UACB_FAC_LOW  17'h00040
`define UACB_FAC_HIGH 17'h00010

`endif

/* File: rtl/uacb_pkg.sv */
package uacb_pkg;

   // Flags kept by the external status logic
   typedef struct packed {
      logic overrun_flag;
      logic receive_available_flag;
      logic transmitter_idle_flag;
      logic transmit_empty_flag;
   } uacb_flags_t;

   // Word handed over by the receive shifter
   typedef struct packed {
      logic       received_ninth_bit;
      logic [7:0] data;
   } uacb_rxw_t;

   // Pin driver pair, oe_n low while driving
   typedef struct packed {
      logic o;
      logic oe_n;
   } uacb_pin_t;

   // Complete state of the control block
   typedef struct packed {
      logic [7:0]  ctrl;
      logic        single_line_mode;
      logic        port_global_on;
      logic        word_length_select;
      logic [7:0]  txd;
      logic [7:0]  rxd;
      logic        rx9;
      logic [7:0]  divisor_bits;
      logic [5:0]  pre;
      logic [7:0]  cnt;
      logic        tick;
      logic        tx_load;
      logic        rx_taken;
      logic        rx_read;
      logic        irq_set;
      logic        wake_req;
      logic        pin_q;
      uacb_flags_t flg_q;
      logic [31:0] prd;
   } uacb_state_t;

endpackage

/* File: sim/uacb_peer.sv */
`timescale 1ns/1ns
`default_nettype none
////////////////////////////////////////
// Far-end serial peer: resolves both lines, pull-ups when released
module uacb_peer (
   // Clock
   input  wire logic                 pclk,
   // Pin drivers of the block
   input  wire uacb_pkg::uacb_pin_t  tx_pin,
   input  wire uacb_pkg::uacb_pin_t  rxtx_pin,
   // Resolved line levels
   output logic                      tx_line,
   output logic                      rxtx_line
);
   import uacb_pkg::*;
   logic peer_lo = 1'b0;
   // A floating line rests high, never at a stale value
   assign tx_line   = tx_pin.oe_n ? 1'b1 : tx_pin.o;
   assign rxtx_line = !rxtx_pin.oe_n ? rxtx_pin.o : !peer_lo;
   // Peer pulls the shared line low for n cycles, changed after an edge
   task pull_low(input int n);
      @(posedge pclk);
      peer_lo <= 1'b1;
      repeat (n) @(posedge pclk);
      peer_lo <= 1'b0;
   endtask
endmodule
`default_nettype wire

/* File: sim/tb_uart_control_and_baud_generator.sv */
`timescale 1ns/1ns
`default_nettype none
`include "uacb_defs.svh"
// Counted compare of two values
`define CHK(g, e) chk(32'(g), 32'(e))
module tb_uart_control_and_baud_generator;
   import uacb_pkg::*;
   // Stimulus and observed outputs
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   uacb_flags_t flags_i;
   uacb_rxw_t   rx_word;
   logic        rx_valid, ser_tx_bit, clk_off, port_run, tx_run, rx_run;
   logic        wls, baud_tick, tx_load, rx_taken, rx_read, rx_line;
   logic        irq_set, wake_req, tx_line, rxtx_line, last_err;
   logic [7:0]  tx_data, d, last;
   logic [5:0]  t;
   uacb_pin_t   tx_pin, rxtx_pin;
   int          n_errors, total_checks, cyc, n_irq, n_wake, n_take;
   int          n_tick, n_load, n_rdp, c, ci, g, n;
   logic [31:0] expq[$];
   // Row: swm, tx on, rx on, shared oe_n, tx oe_n, tx oe_n defined
   logic [5:0]  pins[5] = '{6'h1d, 6'h33, 6'h3c, 6'h2f, 6'h07};
   // Row: clock off, wake bit, wake expected
   logic [2:0]  wk[3] = '{3'h7, 3'h2, 3'h4};

   always #50 pclk = ~pclk;

   uacb_ctrl i_uacb_ctrl (.pclk, .presetn, .paddr, .psel, .penable,
      .pwrite, .pwdata, .prdata, .pready, .pslverr, .flags_i, .rx_valid,
      .rx_word, .ser_tx_bit, .clk_off, .port_run, .tx_run, .rx_run,
      .word_length_select(wls), .baud_tick, .tx_data, .tx_load,
      .rx_taken, .rx_read, .rx_line, .irq_set, .wake_req, .tx_pin,
      .rxtx_pin_i(rxtx_line), .rxtx_pin);
   uacb_peer i_uacb_peer (.pclk, .tx_pin, .rxtx_pin, .tx_line,
      .rxtx_line);

   ////////////////////////////////////////
   task chk(input logic [31:0] g, input logic [31:0] e);
      total_checks++;
      if (g !== e) begin
         n_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task stop_test;
      $display("checks=%0d errors=%0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // Setup then access, held until pready is seen at an edge
   task apb(input logic [11:0] a, input logic w, input logic [31:0] wd);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      paddr <= a;
      pwrite <= w;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task wr(input logic [11:0] a, input logic [31:0] wd);
      apb(a, 1'b1, wd);
   endtask
   // Expected read data is queued before the bus cycle starts
   task rd(input logic [11:0] a, input logic [31:0] e);
      expq.push_back(e);
      apb(a, 1'b0, 32'h0);
   endtask
   task setf(input uacb_flags_t v);
      @(posedge pclk);
      flags_i <= v;
   endtask
   task rxw(input uacb_rxw_t w);
      @(posedge pclk);
      rx_valid <= 1'b1;
      rx_word <= w;
      @(posedge pclk);
      rx_valid <= 1'b0;
      repeat (2) @(posedge pclk);
   endtask
   // Cycles from one baud tick to the next
   task gap(output int w);
      w = 0;
      do @(posedge pclk); while (baud_tick !== 1'b1);
      do begin
         @(posedge pclk);
         w++;
      end while (baud_tick !== 1'b1);
   endtask

   ////////////////////////////////////////
   // Read results leave the queue oldest first
   always @(posedge pclk) begin
      if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 &&
          pwrite === 1'b0) begin
         last_err = pslverr;
         `CHK(prdata, expq.pop_front());
      end
   end
   // Pulses counted mid-cycle, away from the launching edge
   always @(negedge pclk) begin
      n_irq += (irq_set === 1'b1);
      n_wake += (wake_req === 1'b1);
      n_take += (rx_taken === 1'b1);
      n_tick += (baud_tick === 1'b1);
      n_load += (tx_load === 1'b1);
      n_rdp += (rx_read === 1'b1);
   end
   // Hang guard, well above the expected run length
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin
         n_errors++;
         stop_test;
      end
   end

   initial begin
      {presetn, psel, penable, pwrite, rx_valid, clk_off} = '0;
      {paddr, pwdata, flags_i, rx_word} = '0;
      ser_tx_bit = 1'b1;
      pclk = 1'b0;
      void'($urandom(32'ha158));
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      // Pins float and registers clear after reset
      `CHK({tx_pin.oe_n, rxtx_pin.oe_n}, 2'b11);
      rd(`UACB_OFF_CTRL2, 0);
      rd(`UACB_OFF_SLINE, 0);
      rd(12'h018, 0);
      @(posedge pclk);
      `CHK(last_err, 1);
      d = $urandom;
      wr(`UACB_OFF_CTRL2, d);
      rd(`UACB_OFF_CTRL2, d & 8'h3f);
      wr(`UACB_OFF_PORT, 1);
      foreach (pins[i]) begin
         t = pins[i];
         wr(`UACB_OFF_SLINE, {7'h7f, t[5]});
         rd(`UACB_OFF_SLINE, t[5]);
         wr(`UACB_OFF_CTRL2, {t[4], t[3], 6'h0});
         ser_tx_bit <= $urandom;
         @(negedge pclk);
         `CHK({tx_run, rx_run}, t[4:3]);
         `CHK(rxtx_pin.oe_n, t[2]);
         `CHK(rx_line, t[3] ? rxtx_line : 1'b1);
         if (!t[2]) `CHK(rxtx_line, ser_tx_bit);
         if (t[0]) `CHK(tx_pin.oe_n, t[1]);
         if (t[0] && !t[1]) `CHK(tx_line, ser_tx_bit);
      end
      // Data byte taken only while transmit register empty
      wr(`UACB_OFF_CTRL2, 8'hc0);
      setf(4'h1);
      d = $urandom;
      c = n_load;
      wr(`UACB_OFF_DATA, d);
      setf(4'h0);
      wr(`UACB_OFF_DATA, ~d);
      repeat (2) @(posedge pclk);
      `CHK(n_load - c, 1);
      `CHK(tx_data, d);
      // Address words stored, data words dropped
      for (int m = 0; m < 2; m++) begin
         wr(`UACB_OFF_PORT, 1 | (m << 1));
         wr(`UACB_OFF_CTRL2, 8'hd0);
         `CHK(wls, m);
         for (int k = 1; k >= 0; k--) begin
            d = $urandom;
            c = n_take;
            rxw(m ? {k[0], d} : {1'b0, k[0], d[6:0]});
            if (k) last = m ? d : {1'b1, d[6:0]};
            `CHK(n_take - c, k);
            rd(`UACB_OFF_DATA, last);
         end
      end
      // Each flag interrupts only when enabled
      for (int e = 0; e < 2; e++)
         for (int i = 0; i < 4; i++) begin
            setf(4'h0);
            wr(`UACB_OFF_CTRL2, 8'hc0 | (e << (i > 1 ? 2 : i)));
            c = n_irq;
            setf(4'h1 << i);
            repeat (3) @(posedge pclk);
            `CHK(n_irq - c, e);
            rd(`UACB_OFF_STAT, 5'h10 | (4'h1 << i));
         end
      // Wake only with clock off and wake bit set
      setf(4'h0);
      foreach (wk[i]) begin
         clk_off <= wk[i][2];
         wr(`UACB_OFF_CTRL2, {4'h4, wk[i][1], 3'h4});
         c = n_wake;
         ci = n_irq;
         i_uacb_peer.pull_low(3);
         repeat (2) @(posedge pclk);
         `CHK(n_wake - c, wk[i][0]);
         `CHK(n_irq - ci, wk[i][0]);
      end
      clk_off <= 1'b0;
      // Tick period per speed, silent while off
      for (int s = 0; s < 2; s++) begin
         n = $urandom_range(3, 0);
         wr(`UACB_OFF_PORT, 0);
         wr(`UACB_OFF_DIV, n);
         wr(`UACB_OFF_CTRL2, s << 5);
         c = n_tick;
         repeat (100) @(posedge pclk);
         `CHK(n_tick - c, 0);
         wr(`UACB_OFF_PORT, 1);
         gap(g);
         `CHK(g, (s ? 16 : 64) * (n + 1));
      end
      // Port off drops both enables, keeps the rest
      wr(`UACB_OFF_CTRL2, 8'hff);
      wr(`UACB_OFF_PORT, 0);
      rd(`UACB_OFF_CTRL2, 8'h3f);
      rd(`UACB_OFF_DIV, n);
      @(negedge pclk);
      `CHK({tx_run, rx_run, tx_pin.oe_n, rxtx_pin.oe_n}, 4'h3);
      `CHK(port_run, 0);
      `CHK(n_rdp, 4);
      `CHK(expq.size(), 0);
      stop_test;
   end
endmodule
`default_nettype wire
